// *** ssd_pkg.sv ***
// constants, field layout and carrier types for the surface state decoder
// assumes a 32-bit register bus and six descriptor words held by software
package ssd_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          DESC_WORDS    = 6;
  localparam int          IDX_W         = 6;
  localparam logic [5:0]  IDX_DESC_LAST = 6'h05;
  localparam logic [5:0]  IDX_ROW_REQ   = 6'h06;
  localparam logic [5:0]  IDX_ROW_RES   = 6'h07;
  localparam logic [5:0]  IDX_ENTRIES   = 6'h08;
  localparam logic [5:0]  IDX_START     = 6'h09;
  localparam logic [5:0]  IDX_STATUS    = 6'h0A;
  localparam logic [31:0] DESC_RST      = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;
  localparam int          STAT_ROT_BIT  = 0;
  localparam int          STAT_BND_BIT  = 1;

  // ----------------------------------------------------------------
  // descriptor word indices and field positions
  // ----------------------------------------------------------------
  localparam int DW_CTRL = 0;
  localparam int DW_BASE = 1;
  localparam int DW_SIZE = 2;
  localparam int DW_DEP  = 3;
  localparam int DW_OFFS = 5;
  localparam int TYPE_HI = 31;
  localparam int TYPE_LO = 29;
  localparam int VS_BIT  = 12;
  localparam int VSO_BIT = 11;
  localparam int BND_HI  = 7;
  localparam int BND_LO  = 6;
  localparam int FACE_HI = 5;
  localparam int FACE_LO = 0;
  localparam int HGT_HI  = 31;
  localparam int HGT_LO  = 19;
  localparam int WID_HI  = 18;
  localparam int WID_LO  = 6;
  localparam int MIP_HI  = 5;
  localparam int MIP_LO  = 2;
  localparam int ROT_HI  = 1;
  localparam int ROT_LO  = 0;
  localparam int DEP_HI  = 31;
  localparam int DEP_LO  = 21;
  localparam int PIT_HI  = 19;
  localparam int PIT_LO  = 3;
  localparam int TIL_BIT = 1;
  localparam int XOF_HI  = 31;
  localparam int XOF_LO  = 25;
  localparam int YOF_HI  = 23;
  localparam int YOF_LO  = 20;
  localparam int ENT_LOW_W = 7;
  localparam int ENT_TOP_W = 7;
  localparam int ROW_IN_W  = 16;
  localparam int ROW_OUT_W = 15;

  // ----------------------------------------------------------------
  // enumerations and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    surface_kind_one_dim      = 3'h0,
    surface_kind_two_dim      = 3'h1,
    surface_kind_volume       = 3'h2,
    surface_kind_cube         = 3'h3,
    surface_kind_linear_array = 3'h4
  } ssd_kind_t;

  typedef enum logic [1:0] {
    nearest_row_same_field        = 2'h0,
    boundary_reserved             = 2'h1,
    whole_frame_nearest_row       = 2'h2,
    parity_preserving_nearest_row = 2'h3
  } ssd_bnd_t;

  typedef enum logic [1:0] {
    rotation_none          = 2'h0,
    rotation_quarter       = 2'h1,
    rotation_reserved      = 2'h2,
    rotation_three_quarter = 2'h3
  } ssd_rot_t;

  typedef struct packed {
    ssd_kind_t    kind;
    logic [12:0]  width_m1;
    logic         width_in_dw;
    logic [12:0]  height_m1;
    logic [10:0]  depth_m1;
    logic [26:0]  entries_m1;
    logic [5:0]   face_mask;
    logic [3:0]   mip;
    logic         mip_is_abs;
    ssd_rot_t     rotation;
    logic         rot_bad;
    logic [16:0]  pitch_m1;
    logic [31:0]  start;
    logic         vstride;
    logic         vstride_odd;
    ssd_bnd_t     boundary;
    logic         bnd_bad;
  } ssd_decode_t;

endpackage

// *** ssd_row_clamp.sv ***
// out-of-range row resolution for media block reads
// assumes height_m1 is the field height when line stride is set
`timescale 1ns/1ps
module ssd_row_clamp
  import ssd_pkg::*;
(
  input  wire logic                        i_field,
  input  wire logic                        i_field_odd,
  input  wire ssd_bnd_t                    i_mode,
  input  wire logic [12:0]                 i_height_m1,
  input  wire logic signed [ROW_IN_W-1:0]  i_row,
  output logic         [ROW_OUT_W-1:0]     o_row
);

  function automatic logic signed [17:0] clamp(
    input logic signed [17:0] v,
    input logic signed [17:0] top);
    if (v < 18'sh00000)
      clamp = 18'sh00000;
    else if (v > top)
      clamp = top;
    else
      clamp = v;
  endfunction

  logic signed [17:0] r;
  logic signed [17:0] h;
  logic signed [17:0] p;
  logic signed [17:0] off;

  always_comb begin
    r   = 18'(i_row);
    h   = {5'h00, i_height_m1};
    off = {17'h00000, i_field_odd};
    p   = clamp(r, h);
    if (i_field) begin
      if (i_mode == whole_frame_nearest_row)
        p = clamp((r <<< 1) + off, (h <<< 1) + 18'sh00001);
      else
        p = (clamp(r, h) <<< 1) + off;
    end else if (i_mode == parity_preserving_nearest_row) begin
      if (r < 18'sh00000)
        p = (r[0] && h != 18'sh00000) ? 18'sh00001 : 18'sh00000;
      else if (r > h)
        p = (r[0] == h[0] || h == 18'sh00000) ? h
                                               : h - 18'sh00001;
    end
    o_row = p[ROW_OUT_W-1:0];
  end

endmodule

// *** ssd_field_decode.sv ***
// combinational decode of the six descriptor words
// assumes the access context inputs are stable for the access in progress
`timescale 1ns/1ps
module ssd_field_decode
  import ssd_pkg::*;
#(
  parameter int BPE_BYTES = 4
) (
  input  wire logic [DESC_WORDS-1:0][31:0] i_desc,
  input  wire logic                        i_render_target,
  input  wire logic                        i_media_access,
  output ssd_decode_t                      o_dec
);

  logic [31:0] w0;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [31:0] w5;
  logic [31:0] yb;
  logic [31:0] xb;

  always_comb begin
    w0 = i_desc[DW_CTRL];
    w2 = i_desc[DW_SIZE];
    w3 = i_desc[DW_DEP];
    w5 = i_desc[DW_OFFS];
    o_dec             = '0;
    o_dec.kind        = ssd_kind_t'(w0[TYPE_HI:TYPE_LO]);
    o_dec.height_m1   = w2[HGT_HI:HGT_LO];
    o_dec.width_m1    = w2[WID_HI:WID_LO];
    o_dec.width_in_dw = i_media_access;
    o_dec.depth_m1    = w3[DEP_HI:DEP_LO];
    o_dec.pitch_m1    = w3[PIT_HI:PIT_LO];
    o_dec.mip         = w2[MIP_HI:MIP_LO];
    o_dec.mip_is_abs  = i_render_target;
    o_dec.vstride     = w0[VS_BIT];
    o_dec.vstride_odd = w0[VSO_BIT];
    o_dec.boundary    = ssd_bnd_t'(w0[BND_HI:BND_LO]);
    o_dec.bnd_bad     = (o_dec.boundary == boundary_reserved);
    o_dec.rotation    = ssd_rot_t'(w2[ROT_HI:ROT_LO]);
    if (o_dec.rotation == rotation_reserved) begin
      o_dec.rot_bad  = 1'b1;
      o_dec.rotation = rotation_none;
    end
    if (o_dec.kind == surface_kind_cube)
      o_dec.face_mask = w0[FACE_HI:FACE_LO];
    if (o_dec.kind == surface_kind_linear_array)
      o_dec.entries_m1 = {w3[DEP_LO+ENT_TOP_W-1:DEP_LO],
                          w2[HGT_HI:HGT_LO],
                          w2[WID_LO+ENT_LOW_W-1:WID_LO]};
    yb = 32'({w5[YOF_HI:YOF_LO], 1'b0})
       * 32'({1'b0, o_dec.pitch_m1} + 18'h00001);
    xb = 32'({w5[XOF_HI:XOF_LO], 2'b00}) * 32'(BPE_BYTES);
    o_dec.start = i_desc[DW_BASE];
    if (w3[TIL_BIT])
      o_dec.start = i_desc[DW_BASE] + yb + xb;
  end

endmodule

// *** ssd_top.sv ***
// surface state decoder: descriptor registers on an Avalon-MM slave,
// decoded surface fields and a row resolver for the consuming access unit
// assumes one clock, the bus master on that clock and software that
// programs legal descriptor values
//
// Overview of operation
// - mode 0: nearest row, same field only
// - mode 2: nearest row of whole frame
// - mode 3: field same field; frame keeps parity
// - cube face mask bits, used only for cubes
// - tiled start is base plus X/Y offsets
// - height field is height minus one
// - buffer entry count split over three fields
// - width field is width minus one
// - media block access counts width in doublewords
// - mip field absolute for targets, count otherwise
// - rotation codes none, quarter, three quarter
// - depth field is array count or depth
// - pitch field is byte pitch minus one
// - line stride skips zero or one line
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module ssd_top
  import ssd_pkg::*;
#(
  parameter int BPE_BYTES = 4
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic [ADDR_W-1:0]    i_address,
  input  wire logic                 i_read,
  input  wire logic                 i_write,
  input  wire logic [DATA_W-1:0]    i_writedata,
  input  wire logic [3:0]           i_byteenable,
  output logic      [DATA_W-1:0]    o_readdata,
  output logic                      o_waitrequest,
  input  wire logic                 i_render_target,
  input  wire logic                 i_media_access,
  output ssd_decode_t               o_decode,
  output logic      [ROW_OUT_W-1:0] o_row
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DESC_WORDS-1:0][31:0]      desc_reg;
  logic signed [ROW_IN_W-1:0]       row_req_reg;
  logic                             wait_reg;
  logic [DATA_W-1:0]                rdata_reg;
  ssd_decode_t                      dec_reg;
  logic [ROW_OUT_W-1:0]             row_reg;

  // ----------------------------------------------------------------
  // combinational results
  // ----------------------------------------------------------------
  ssd_decode_t                      dec_next;
  logic [ROW_OUT_W-1:0]             row_next;
  logic [IDX_W-1:0]                 idx;
  logic                             commit_wr;
  logic                             first_cycle;
  logic [DATA_W-1:0]                rdata_next;
  logic [DATA_W-1:0]                be_mask;
  logic [DATA_W-1:0]                row_merged;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word index of a byte address; low two bits are ignored
  function automatic logic [IDX_W-1:0] word_idx(
    input logic [ADDR_W-1:0] a);
    word_idx = a[ADDR_W-1:2];
  endfunction

  // true when the index names one of the descriptor words
  function automatic logic is_desc(input logic [IDX_W-1:0] i);
    is_desc = (i <= IDX_DESC_LAST);
  endfunction

  // expand byte enables into a bit mask
  function automatic logic [DATA_W-1:0] lane_mask(
    input logic [3:0] be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      if (be[b])
        m[b*8 +: 8] = 8'hFF;
    end
    lane_mask = m;
  endfunction

  // merge new write data into a stored word lane by lane
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // every access gets exactly one wait state: the request is seen with
  // waitrequest high, answered on the next edge, and committed at the
  // edge where the master samples waitrequest low
  assign idx         = word_idx(i_address);
  assign first_cycle = (i_read | i_write) & wait_reg;
  assign commit_wr   = i_write & ~wait_reg;
  assign be_mask     = lane_mask(i_byteenable);
  assign row_merged  = merge({16'h0000, row_req_reg}, i_writedata, be_mask);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~first_cycle;
    end
  end

  // ----------------------------------------------------------------
  // descriptor words
  // ----------------------------------------------------------------
  genvar gw;
  generate
    for (gw = 0; gw < DESC_WORDS; gw++) begin : g_desc
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          desc_reg[gw] <= DESC_RST;
        end else if (commit_wr && idx == IDX_W'(gw)) begin
          desc_reg[gw] <= merge(desc_reg[gw], i_writedata, be_mask);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // row request
  // ----------------------------------------------------------------
  // a software written row index probes the boundary resolver; the
  // resolved row follows one cycle after the write commits
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      row_req_reg <= '0;
    end else if (commit_wr && idx == IDX_ROW_REQ) begin
      row_req_reg <= row_merged[ROW_IN_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // field decode carries no state; the only flops are the output
  // stage so that consumers see a clean registered copy
  ssd_field_decode #(
    .BPE_BYTES       (BPE_BYTES)
  ) u_decode (
    .i_desc          (desc_reg),
    .i_render_target (i_render_target),
    .i_media_access  (i_media_access),
    .o_dec           (dec_next)
  );

  ssd_row_clamp u_clamp (
    .i_field     (dec_next.vstride),
    .i_field_odd (dec_next.vstride_odd),
    .i_mode      (dec_next.boundary),
    .i_height_m1 (dec_next.height_m1),
    .i_row       (row_req_reg),
    .o_row       (row_next)
  );

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      row_reg <= '0;
    end else begin
      row_reg <= row_next;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // descriptor words are read straight from desc_reg, so a read issued the
  // cycle after a write sees the new word; decoded values and row lag a cycle more
  always_comb begin
    rdata_next = RD_UNMAPPED;
    if (is_desc(idx)) begin
      rdata_next = desc_reg[idx[2:0]];
    end else begin
      case (idx)
        IDX_ROW_REQ: begin
          rdata_next = 32'(unsigned'(row_req_reg));
        end
        IDX_ROW_RES: begin
          rdata_next = 32'(row_reg);
        end
        IDX_ENTRIES: begin
          rdata_next = 32'(dec_reg.entries_m1);
        end
        IDX_START: begin
          rdata_next = dec_reg.start;
        end
        IDX_STATUS: begin
          rdata_next[STAT_ROT_BIT] = dec_reg.rot_bad;
          rdata_next[STAT_BND_BIT] = dec_reg.bnd_bad;
        end
        default: begin
          rdata_next = RD_UNMAPPED;
        end
      endcase
    end
  end

  // read data is captured on the first cycle of the access and then
  // held, so it stands at the edge where the master takes it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= '0;
    end else if (first_cycle && i_read) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  assign o_readdata    = rdata_reg;
  assign o_waitrequest = wait_reg;
  assign o_decode      = dec_reg;
  assign o_row         = row_reg;

endmodule

// *** ssd_checker.sv ***
// port assertions for the surface state decoder
// assumes it is bound to ssd_top and that the bus master keeps its handshake
`timescale 1ns/1ps
module ssd_checker
  import ssd_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic [ADDR_W-1:0]    i_address,
  input  wire logic                 i_read,
  input  wire logic                 i_write,
  input  wire logic [DATA_W-1:0]    i_writedata,
  input  wire logic [3:0]           i_byteenable,
  input  wire logic [DATA_W-1:0]    o_readdata,
  input  wire logic                 o_waitrequest,
  input  wire logic                 i_render_target,
  input  wire logic                 i_media_access,
  input  wire ssd_decode_t          o_decode,
  input  wire logic [ROW_OUT_W-1:0] o_row
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // $past is only trusted once a few edges have passed since reset
  logic [1:0] up_reg;
  logic       settled;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  assign settled = (up_reg == 2'h3);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_taken;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence s_answer;
    !o_waitrequest ##1 o_waitrequest;
  endsequence
  sequence s_row_steady;
    $stable(o_decode) [*2];
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_bus_one_wait: assert property (
    s_taken |=> s_answer)
    else $error("bus answer is not exactly one wait state");
  a_wait_has_cause: assert property (
    !o_waitrequest |-> $past(o_waitrequest) && $past(i_read || i_write))
    else $error("waitrequest dropped without a request");
  a_unmapped_reads_zero: assert property (
    i_read && o_waitrequest && i_address[7:2] > IDX_STATUS
    |=> o_readdata == RD_UNMAPPED)
    else $error("unmapped read returned data");
  a_media_width_unit: assert property (
    settled |-> o_decode.width_in_dw == $past(i_media_access))
    else $error("width unit does not follow media access");
  a_target_mip_mode: assert property (
    settled |-> o_decode.mip_is_abs == $past(i_render_target))
    else $error("mip reading does not follow render target");
  a_face_mask_gate: assert property (
    o_decode.kind != surface_kind_cube |-> o_decode.face_mask == 6'h00)
    else $error("face mask not cleared for non-cube surface");
  a_entries_split: assert property (
    o_decode.entries_m1 == ((o_decode.kind == surface_kind_linear_array) ?
      {o_decode.depth_m1[6:0], o_decode.height_m1, o_decode.width_m1[6:0]}
      : 27'h0))
    else $error("entry count not assembled from three fields");
  a_rotation_reserved: assert property (
    o_decode.rot_bad |-> o_decode.rotation == rotation_none)
    else $error("reserved rotation passed through");
  a_frame_row_clamp: assert property (
    s_row_steady ##0 (!o_decode.vstride &&
    o_decode.boundary != parity_preserving_nearest_row)
    |-> o_row <= 15'(o_decode.height_m1))
    else $error("frame row beyond surface height");
  a_field_row_parity: assert property (
    s_row_steady ##0 (o_decode.vstride &&
    o_decode.boundary != whole_frame_nearest_row)
    |-> o_row[0] == o_decode.vstride_odd)
    else $error("field row left its field");
endmodule

// *** ssd_access_unit.sv ***
// model of the consuming access unit beside the decoder
// assumes bench commands change just after a rising edge
`timescale 1ns/1ps
module ssd_access_unit
  import ssd_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_rt_cmd,
  input  wire logic                 i_media_cmd,
  input  wire logic [ROW_OUT_W-1:0] i_row,
  output logic                      o_render_target,
  output logic                      o_media_access,
  output logic      [ROW_OUT_W-1:0] o_row_seen
);
  // the access context follows the bench commands one edge later; the decoder expects it held for an access
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_render_target <= 1'b0;
      o_media_access  <= 1'b0;
      o_row_seen      <= 15'h0000;
    end else begin
      o_render_target <= i_rt_cmd;
      o_media_access  <= i_media_cmd;
      o_row_seen      <= i_row;
    end
  end
endmodule

// *** tb.sv ***
// self-checking bench for the surface state decoder
// assumes ssd_pkg, ssd_top, ssd_access_unit and ssd_checker compiled first
`timescale 1ns/1ps
module tb
  import ssd_pkg::*;
;
  localparam int BPE = 4;
  logic                 clk;
  logic                 nrst;
  logic [ADDR_W-1:0]    address;
  logic                 read;
  logic                 write;
  logic [DATA_W-1:0]    writedata;
  logic [DATA_W-1:0]    readdata;
  logic                 waitreq;
  logic                 rt;
  logic                 media;
  logic                 rt_cmd;
  logic                 media_cmd;
  ssd_decode_t          dec;
  logic [ROW_OUT_W-1:0] row;
  logic [ROW_OUT_W-1:0] row_seen;
  int                   bad_count;
  int                   cmp_count;

  ssd_top #(.BPE_BYTES(BPE)) i_dut (
    .i_clk(clk), .i_nrst(nrst), .i_address(address), .i_read(read),
    .i_write(write), .i_writedata(writedata), .i_byteenable(4'hF),
    .o_readdata(readdata), .o_waitrequest(waitreq),
    .i_render_target(rt), .i_media_access(media), .o_decode(dec),
    .o_row(row));
  ssd_access_unit i_unit (
    .i_clk(clk), .i_nrst(nrst), .i_rt_cmd(rt_cmd), .i_media_cmd(media_cmd),
    .i_row(row), .o_render_target(rt), .o_media_access(media),
    .o_row_seen(row_seen));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // request stands until the rising edge at which waitrequest is sampled
  // low; read data is taken at that same edge, then the request drops
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address   <= a;
    read      <= !w;
    write     <= w;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 40);
    q = readdata;
    if (waitreq !== 1'b0) begin
      bad_count++;
    end
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rchk(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    cmp(name, exp, q);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] ctrl(input ssd_kind_t k, input logic vs,
      input logic odd, input logic [1:0] bnd, input logic [5:0] face);
    return {k, 16'h0, vs, odd, 3'h0, bnd, face};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < DESC_WORDS; i++) begin
      rchk("desc word", 8'(i * 4), DESC_RST);
    end
    cmp("start", 32'h0, dec.start);
  endtask

  task automatic t_sizes();
    rt_cmd    <= 1'b1;
    media_cmd <= 1'b1;
    wreg(8'h00, ctrl(surface_kind_two_dim, 1'b0, 1'b0, 2'h0, 6'h3F));
    wreg(8'h08, {13'h1FFF, 13'h1FFF, 4'hD, 2'h0});
    wreg(8'h0C, {11'h1FF, 1'b0, 17'h1FFFF, 3'h0});
    settle();
    cmp("height", 32'h1FFF, 32'(dec.height_m1));
    cmp("width", 32'h1FFF, 32'(dec.width_m1));
    cmp("depth", 32'h1FF, 32'(dec.depth_m1));
    cmp("pitch", 32'h1FFFF, 32'(dec.pitch_m1));
    cmp("mip", 32'hD, 32'(dec.mip));
    cmp("mip abs", 32'h1, 32'(dec.mip_is_abs));
    cmp("width dw", 32'h1, 32'(dec.width_in_dw));
    cmp("face", 32'h0, 32'(dec.face_mask));
    rchk("size word", 8'h08, {13'h1FFF, 13'h1FFF, 4'hD, 2'h0});
    rt_cmd    <= 1'b0;
    media_cmd <= 1'b0;
    settle();
    cmp("mip abs", 32'h0, 32'(dec.mip_is_abs));
    cmp("width dw", 32'h0, 32'(dec.width_in_dw));
  endtask

  task automatic t_buffer();
    logic [26:0] e;
    e = 27'h5A3C96B;
    wreg(8'h00, ctrl(surface_kind_linear_array, 1'b0, 1'b0, 2'h0, 6'h00));
    wreg(8'h08, {e[19:7], 6'h00, e[6:0], 6'h00});
    wreg(8'h0C, {4'h0, e[26:20], 21'h0});
    settle();
    rchk("entries", 8'h20, {5'h0, e});
    cmp("entries dec", {5'h0, e}, 32'(dec.entries_m1));
    cmp("kind", 32'h4, 32'(dec.kind));
  endtask

  task automatic t_cube();
    for (int i = 0; i < 6; i++) begin
      wreg(8'h00, ctrl(surface_kind_cube, 1'b0, 1'b0, 2'h0, 6'h01 << i));
      settle();
      cmp("face", 32'h1 << i, 32'(dec.face_mask));
    end
  endtask

  task automatic t_rot();
    for (int r = 0; r < 4; r++) begin
      wreg(8'h08, {13'h0009, 13'h000F, 4'h0, 2'(r)});
      settle();
      cmp("rotation", (r == 2) ? 32'h0 : 32'(r), 32'(dec.rotation));
      rchk("status", 8'h28, (r == 2) ? 32'h1 : 32'h0);
    end
  endtask

  task automatic t_start();
    logic [31:0] base;
    base = 32'h0004_2000;
    wreg(8'h00, ctrl(surface_kind_two_dim, 1'b0, 1'b0, 2'h0, 6'h00));
    wreg(8'h04, base);
    wreg(8'h0C, {11'h0, 1'b0, 17'h001FF, 3'h2});
    wreg(8'h14, {7'h03, 1'b0, 4'h2, 20'h0});
    settle();
    rchk("start", 8'h24, base + 32'(4 * 512 + 12 * BPE));
    wreg(8'h0C, {11'h0, 1'b0, 17'h001FF, 3'h0});
    wreg(8'h24, 32'hFFFF_FFFF);
    settle();
    rchk("start", 8'h24, base);
    wreg(8'h2C, 32'h1234_5678);
    rchk("unmapped", 8'h2C, RD_UNMAPPED);
  endtask

  // height field 9 (ten rows) left by t_rot; fo is field select, odd field
  task automatic t_rows();
    int md[13] = '{0, 0, 2, 3, 3, 3, 0, 2, 2, 2, 3, 0, 1};
    int fo[13] = '{0, 0, 0, 0, 0, 0, 3, 3, 2, 2, 3, 2, 0};
    int rw[13] = '{-3, 20, 20, -3, 20, 21, 20, -1, 5, 20, -2, 3, -3};
    int ex[13] = '{0, 9, 9, 1, 8, 9, 19, 0, 10, 19, 1, 6, 0};
    for (int i = 0; i < 13; i++) begin
      wreg(8'h00, ctrl(surface_kind_two_dim, fo[i][1], fo[i][0],
                       2'(md[i]), 6'h00));
      wreg(8'h18, {16'h0, 16'(rw[i])});
      settle();
      rchk("row", 8'h1C, 32'(ex[i]));
      cmp("row port", 32'(ex[i]), 32'(row));
      cmp("row seen", 32'(ex[i]), 32'(row_seen));
      rchk("row req", 8'h18, {16'h0, 16'(rw[i])});
    end
    rchk("status", 8'h28, 32'h2);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    nrst      = 1'b0;
    address   = 8'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0;
    rt_cmd    = 1'b0;
    media_cmd = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_sizes();
    t_buffer();
    t_cube();
    t_rot();
    t_start();
    t_rows();
    finish_test();
  end

  // the whole run needs a few hundred cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule

bind ssd_top ssd_checker i_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read),
  .i_write(i_write), .i_writedata(i_writedata),
  .i_byteenable(i_byteenable), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .i_render_target(i_render_target),
  .i_media_access(i_media_access), .o_decode(o_decode), .o_row(o_row));
